// ### design/led_port_defs.svh
// Register offsets, field positions, reset values and link constants
`ifndef LED_PORT_DEFS_SVH
`define LED_PORT_DEFS_SVH

`define CHIP_SEL_INDEP 3'h5
`define CHIP_SEL_BCAST 5'h1b
`define BYTE_LAST_BIT 4'h7
`define BYTE_BITS 4'h8
`define RW_BIT 0

`define OFS_CHIP_EN 10'h000
`define OFS_CFG_FIRST 10'h001
`define CFG_COUNT 13
`define OFS_UPDATE 10'h010
`define OFS_START 10'h011
`define OFS_STOP 10'h012
`define OFS_PAUSE 10'h013
`define OFS_RESUME 10'h014
`define OFS_CHAN_EN 10'h020
`define OFS_FAULT_CLR 10'h022
`define OFS_SOFT_RST 10'h023
`define OFS_MAN_CUR 10'h030
`define OFS_MAN_DUTY 10'h040
`define OFS_AUTO_CUR 10'h050
`define OFS_PAT_CH0 10'h080
`define OFS_PAT_CH1 10'h09a
`define OFS_PAT_CH2 10'h0b4
`define OFS_PAT_CH3 10'h0ce
`define PAT_BLOCK_LEN 26
`define OFS_RW_LAST 10'h0e7
`define MEM_DEPTH 232

`define OFS_STATUS 10'h300
`define OFS_OPEN 10'h301
`define OFS_SHORT 10'h303
`define OFS_LIVE_DUTY 10'h305
`define OFS_PROGRESS 10'h315
`define OFS_RO_LAST 10'h31c

`define CHIP_EN_BIT 0
`define REG_RESET 8'h00
`define UNMAPPED_READ 8'h00

`endif

// ### design/led_port_pkg.sv
// Types shared by the LED driver serial register port
package led_port_pkg;
  typedef enum logic [1:0] {
    DRV_INITIAL, DRV_STANDBY, DRV_RUNNING, DRV_PAUSED
  } drv_state_e;

  typedef enum logic [2:0] {
    LNK_IDLE, LNK_CHIP, LNK_REGLO, LNK_WRITE, LNK_READ, LNK_SKIP
  } link_state_e;

  typedef struct packed {
    logic enable_on;
    logic update;
    logic start;
    logic stop;
    logic pause;
    logic resume;
    logic fault_clear;
    logic soft_reset;
  } cmd_pulse_s;

  typedef struct packed {
    logic [7:0] thermal_cfg;
    logic [1:0][7:0] open_led;
    logic [1:0][7:0] short_led;
    logic [15:0][7:0] live_duty;
    logic [7:0][7:0] progress;
  } status_in_s;

  typedef logic [3:0][7:0] chan_bytes_t;
  typedef logic [12:0][7:0] cfg_bytes_t;
endpackage

// ### design/led_serial_port.sv
// Serial register port and register map of a four-channel LED driver
`timescale 1ns/1ps
`default_nettype none
`include "led_port_defs.svh"

// Overview of operation
// - Every bus byte is eight bits, most significant bit first.
// - First byte holds five chip-address bits then register address bits 9:8.
// - First byte bit 0 selects direction: one reads, zero writes.
// - Second byte holds register address bits 7:0, joined to the upper two.
// - Answer chip bits 101 plus own two variant bits.
// - Also answer broadcast pattern 11011 in the top five bits.
// - Register address advances after every data byte within a transfer.
// - Configuration bytes take effect only when the update command is written.
// - Start command begins or restarts autonomous animation.
// - Stop command returns the driver to its initial state from anywhere.
// - Pause command suspends autonomous animation.
// - Continue command resumes suspended autonomous animation.
// - Fault clear write clears thermal, open and short fault flags.
// - Four manual current and four manual duty registers.
// - Four autonomous current registers.
// - Four 26-byte pattern blocks at 080, 09A, 0B4 and 0CE.
// - Status register shows thermal shutdown and configuration error.
// - Two registers show open-LED detection results.
// - Two registers show shorted-LED detection results.
// - Registers show the live duty values applied to each output.
// - Registers show each channel's pattern playback progress.
// - Acknowledge on the ninth clock after every received byte of a transfer whose chip address matched.
// - Stay initial after power-up until chip enable is written one.
module led_serial_port #(
  parameter logic [1:0] CHIP_VARIANT = 2'h0  // Arbitrary variant bits
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire led_port_pkg::status_in_s status_in,
  input wire logic [6:0] pat_rd_addr,
  output logic [7:0] pat_rd_data,
  output led_port_pkg::cmd_pulse_s cmd,
  output led_port_pkg::drv_state_e drv_state,
  output led_port_pkg::cfg_bytes_t applied_cfg,
  output logic [7:0] chip_enable,
  output logic [7:0] chan_enable,
  output led_port_pkg::chan_bytes_t manual_current_setting,
  output led_port_pkg::chan_bytes_t manual_duty_setting,
  output led_port_pkg::chan_bytes_t autonomous_current_setting
);

  logic rst_meta;
  logic rst_n;
  logic scl_meta, scl_s, scl_q;
  logic sda_meta, sda_s, sda_q;
  led_port_pkg::link_state_e lnk;
  logic [3:0] bit_cnt;
  logic ack_phase;
  logic ack_due;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [9:0] ptr;
  logic wr_stb;
  logic [9:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] mem [0:`MEM_DEPTH-1];
  logic [7:0] next_tx;
  logic [7:0] byte_in;
  logic start_cond, stop_cond, scl_rise, scl_fall;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Pins are asynchronous to sys_clk; the third stage feeds edge detection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_meta <= scl;
      scl_s <= scl_meta;
      scl_q <= scl_s;
      sda_meta <= sda_in;
      sda_s <= sda_meta;
      sda_q <= sda_s;
    end
  end

  assign start_cond = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_cond = scl_s & scl_q & ~sda_q & sda_s;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign byte_in = {shreg[6:0], sda_s};

  function automatic logic chip_match(input logic [7:0] b);
    chip_match = (b[7:5] == `CHIP_SEL_INDEP && b[4:3] == CHIP_VARIANT)
      || b[7:3] == `CHIP_SEL_BCAST;
  endfunction

  // Soft reset has no storage, so it reads back as zero
  function automatic logic writable(input logic [9:0] a);
    writable = a <= `OFS_RW_LAST && a != `OFS_SOFT_RST;
  endfunction

  function automatic logic [7:0] read_byte(input logic [9:0] a);
    read_byte = `UNMAPPED_READ;
    if (writable(a))
      read_byte = mem[a[7:0]];
    else if (a == `OFS_STATUS)
      read_byte = status_in.thermal_cfg;
    else if (a >= `OFS_OPEN && a < `OFS_SHORT)
      read_byte = status_in.open_led[1'(a - `OFS_OPEN)];
    else if (a >= `OFS_SHORT && a < `OFS_LIVE_DUTY)
      read_byte = status_in.short_led[1'(a - `OFS_SHORT)];
    else if (a >= `OFS_LIVE_DUTY && a < `OFS_PROGRESS)
      read_byte = status_in.live_duty[4'(a - `OFS_LIVE_DUTY)];
    else if (a >= `OFS_PROGRESS && a <= `OFS_RO_LAST)
      read_byte = status_in.progress[3'(a - `OFS_PROGRESS)];
  endfunction

  // A continuous assign would only wake on ptr and miss register updates
  always_comb next_tx = read_byte(ptr);

  // Serial link: byte framing, addressing, acknowledge and read shifting
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk <= led_port_pkg::LNK_IDLE;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      ack_due <= 1'b0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= 10'h000;
      wr_stb <= 1'b0;
      wr_addr <= 10'h000;
      wr_data <= 8'h00;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      sda_out <= 1'b0;
      if (start_cond) begin
        lnk <= led_port_pkg::LNK_CHIP;
        bit_cnt <= 4'h0;
        ack_phase <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_cond) begin
        lnk <= led_port_pkg::LNK_IDLE;
        ack_phase <= 1'b0;
        sda_oe <= 1'b0;
      end else if (lnk != led_port_pkg::LNK_IDLE && scl_rise) begin
        if (ack_phase) begin
          if (lnk == led_port_pkg::LNK_READ && sda_s)
            lnk <= led_port_pkg::LNK_SKIP;
        end else begin
          shreg <= byte_in;
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == `BYTE_LAST_BIT) begin
            case (lnk)
              led_port_pkg::LNK_CHIP: begin
                if (chip_match(byte_in)) begin
                  ptr[9:8] <= byte_in[2:1];
                  ack_due <= 1'b1;
                  if (byte_in[`RW_BIT])
                    lnk <= led_port_pkg::LNK_READ;
                  else
                    lnk <= led_port_pkg::LNK_REGLO;
                end else begin
                  ack_due <= 1'b0;
                  lnk <= led_port_pkg::LNK_SKIP;
                end
              end
              led_port_pkg::LNK_REGLO: begin
                ptr[7:0] <= byte_in;
                ack_due <= 1'b1;
                lnk <= led_port_pkg::LNK_WRITE;
              end
              led_port_pkg::LNK_WRITE: begin
                wr_stb <= 1'b1;
                wr_addr <= ptr;
                wr_data <= byte_in;
                ptr <= ptr + 10'h001;
                ack_due <= 1'b1;
              end
              led_port_pkg::LNK_READ: begin
                ptr <= ptr + 10'h001;
                ack_due <= 1'b0;
              end
              default: ack_due <= 1'b0;
            endcase
          end
        end
      end else if (lnk != led_port_pkg::LNK_IDLE && scl_fall) begin
        if (ack_phase) begin
          ack_phase <= 1'b0;
          bit_cnt <= 4'h0;
          if (lnk == led_port_pkg::LNK_READ) begin
            tx <= next_tx;
            sda_oe <= ~next_tx[7];
          end else begin
            sda_oe <= 1'b0;
          end
        end else if (bit_cnt == `BYTE_BITS) begin
          ack_phase <= 1'b1;
          sda_oe <= ack_due;
        end else if (lnk == led_port_pkg::LNK_READ) begin
          sda_oe <= ~tx[6];
          tx <= {tx[6:0], 1'b0};
        end
      end
    end
  end

  // Register storage; soft reset wipes it in the same cycle as the write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `MEM_DEPTH; i++)
        mem[i] <= `REG_RESET;
    end else if (wr_stb && wr_addr == `OFS_SOFT_RST) begin
      for (int i = 0; i < `MEM_DEPTH; i++)
        mem[i] <= `REG_RESET;
    end else if (wr_stb && writable(wr_addr)) begin
      mem[wr_addr[7:0]] <= wr_data;
    end
  end

  // Staged configuration only reaches the core on the update command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      applied_cfg <= '0;
    end else if (wr_stb && wr_addr == `OFS_SOFT_RST) begin
      applied_cfg <= '0;
    end else if (wr_stb && wr_addr == `OFS_UPDATE) begin
      for (int i = 0; i < `CFG_COUNT; i++)
        applied_cfg[i] <= mem[8'(`OFS_CFG_FIRST + i)];
    end
  end

  // Command pulses; the written value is ignored and any write triggers, except chip enable, which needs bit 0 set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd <= '0;
    end else begin
      cmd <= '0;
      if (wr_stb) begin
        cmd.enable_on <= wr_addr == `OFS_CHIP_EN && wr_data[`CHIP_EN_BIT];
        cmd.update <= wr_addr == `OFS_UPDATE;
        cmd.start <= wr_addr == `OFS_START;
        cmd.stop <= wr_addr == `OFS_STOP;
        cmd.pause <= wr_addr == `OFS_PAUSE;
        cmd.resume <= wr_addr == `OFS_RESUME;
        cmd.fault_clear <= wr_addr == `OFS_FAULT_CLR;
        cmd.soft_reset <= wr_addr == `OFS_SOFT_RST;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drv_state <= led_port_pkg::DRV_INITIAL;
    end else if (cmd.soft_reset || cmd.stop) begin
      drv_state <= led_port_pkg::DRV_INITIAL;
    end else begin
      case (drv_state)
        led_port_pkg::DRV_INITIAL:
          if (cmd.enable_on)
            drv_state <= led_port_pkg::DRV_STANDBY;
        led_port_pkg::DRV_STANDBY:
          if (cmd.start)
            drv_state <= led_port_pkg::DRV_RUNNING;
        led_port_pkg::DRV_RUNNING:
          if (cmd.pause)
            drv_state <= led_port_pkg::DRV_PAUSED;
        led_port_pkg::DRV_PAUSED:
          if (cmd.resume || cmd.start)
            drv_state <= led_port_pkg::DRV_RUNNING;
        default: drv_state <= led_port_pkg::DRV_INITIAL;
      endcase
    end
  end

  // Pattern engine read port, one cycle latency
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      pat_rd_data <= 8'h00;
    else
      pat_rd_data <= mem[8'(`OFS_PAT_CH0 + pat_rd_addr)];
  end

  assign chip_enable = mem[8'(`OFS_CHIP_EN)];
  assign chan_enable = mem[8'(`OFS_CHAN_EN)];

  for (genvar g = 0; g < 4; g++) begin : g_chan
    assign manual_current_setting[g] = mem[8'(`OFS_MAN_CUR + g)];
    assign manual_duty_setting[g] = mem[8'(`OFS_MAN_DUTY + g)];
    assign autonomous_current_setting[g] = mem[8'(`OFS_AUTO_CUR + g)];
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_UPDATE_APPLIES: assert property (
    wr_stb && wr_addr == `OFS_UPDATE |=>
      applied_cfg[0] == $past(mem[1]) && applied_cfg[12] == $past(mem[13]))
    else $error("update did not copy staged configuration");
  AST_CFG_HELD: assert property (
    !(wr_stb && (wr_addr == `OFS_UPDATE || wr_addr == `OFS_SOFT_RST))
      |=> $stable(applied_cfg))
    else $error("applied configuration changed without update");
  AST_AUTOINC: assert property (
    wr_stb |-> ptr == wr_addr + 10'h001)
    else $error("address did not advance after write byte");
  AST_STOP_INITIAL: assert property (
    cmd.stop |=> drv_state == led_port_pkg::DRV_INITIAL)
    else $error("stop did not return to initial");
  AST_START_RUN: assert property (
    cmd.start && !cmd.soft_reset && drv_state != led_port_pkg::DRV_INITIAL
      |=> drv_state == led_port_pkg::DRV_RUNNING)
    else $error("start did not run animation");
  AST_PAUSE: assert property (
    cmd.pause && drv_state == led_port_pkg::DRV_RUNNING
      |=> drv_state == led_port_pkg::DRV_PAUSED)
    else $error("pause did not suspend");
  AST_RESUME: assert property (
    cmd.resume && drv_state == led_port_pkg::DRV_PAUSED
      |=> drv_state == led_port_pkg::DRV_RUNNING)
    else $error("continue did not resume");
  AST_FAULT_PULSE: assert property (
    wr_stb && wr_addr == `OFS_FAULT_CLR |=> cmd.fault_clear ##1 !cmd.fault_clear)
    else $error("fault clear pulse wrong");
  AST_INIT_HOLD: assert property (
    drv_state == led_port_pkg::DRV_INITIAL && !cmd.enable_on
      |=> drv_state == led_port_pkg::DRV_INITIAL)
    else $error("left initial without chip enable");
  AST_SOFT_RESET: assert property (
    cmd.soft_reset |-> mem[0] == `REG_RESET && applied_cfg == '0)
    else $error("soft reset left register contents");
  AST_SKIP_SILENT: assert property (
    lnk == led_port_pkg::LNK_SKIP |-> !sda_oe)
    else $error("drove bus while not addressed");
  AST_READ_ACK_FREE: assert property (
    lnk == led_port_pkg::LNK_READ && ack_phase && !ack_due |-> !sda_oe)
    else $error("held data line during controller acknowledge");
  AST_ACK_DRIVEN: assert property (
    ack_phase && ack_due |-> sda_oe && !sda_out)
    else $error("no acknowledge on the ninth clock");
  AST_CHIP_DECODE: assert property (
    lnk == led_port_pkg::LNK_CHIP && scl_rise && bit_cnt == `BYTE_LAST_BIT
      |=> ack_due == ($past(byte_in[7:3]) == `CHIP_SEL_BCAST
        || $past(byte_in[7:3]) == {`CHIP_SEL_INDEP, CHIP_VARIANT}))
    else $error("chip address decode wrong");
  AST_BIT_SHIFT: assert property (
    lnk != led_port_pkg::LNK_IDLE && scl_rise && !ack_phase
      |=> shreg[0] == $past(sda_s))
    else $error("received bit not shifted in");
  AST_REGLO_JOIN: assert property (
    lnk == led_port_pkg::LNK_REGLO && scl_rise && bit_cnt == `BYTE_LAST_BIT
      |=> ptr[7:0] == $past(byte_in))
    else $error("low address byte not taken");
  AST_ENABLE_STANDBY: assert property (
    cmd.enable_on && drv_state == led_port_pkg::DRV_INITIAL
      |=> drv_state == led_port_pkg::DRV_STANDBY)
    else $error("chip enable did not reach standby");

endmodule
`default_nettype wire

// ### verification/i2c_ctrl_model.sv
// Bus controller model that drives the serial clock and pulls the data line
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Data moves only mid low phase, so it is stable while clock is high
  task automatic put_bit(input logic b);
    wt(5);
    sda_pull = ~b;
    wt(5);
    scl = 1'b1;
    wt(10);
    scl = 1'b0;
  endtask
  // Sampled late in the high phase, well after the pin sync delay
  task automatic get_bit(output logic b);
    wt(5);
    sda_pull = 1'b0;
    wt(5);
    scl = 1'b1;
    wt(8);
    b = sda;
    wt(2);
    scl = 1'b0;
  endtask
  // Works from idle and as a repeated start from a low clock
  task automatic start();
    wt(5);
    sda_pull = 1'b0;
    wt(5);
    scl = 1'b1;
    wt(10);
    sda_pull = 1'b1;
    wt(10);
    scl = 1'b0;
  endtask
  task automatic stop();
    wt(5);
    sda_pull = 1'b1;
    wt(5);
    scl = 1'b1;
    wt(10);
    sda_pull = 1'b0;
    wt(10);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask
  // Last byte refused to end the read
  task automatic rd_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask
endmodule
`default_nettype wire

// ### verification/tb_led_serial_port.sv
// Self-checking bench for the LED driver serial register port
`timescale 1ns/1ps
`default_nettype none
module tb_led_serial_port;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic scl, sda_pull, sda_out, sda_oe, sda, ack;
  led_port_pkg::status_in_s status_in;
  logic [6:0] pat_rd_addr = 7'h00;
  logic [7:0] pat_rd_data, chip_enable, chan_enable, last_cmd;
  led_port_pkg::cmd_pulse_s cmd;
  led_port_pkg::drv_state_e drv_state;
  led_port_pkg::cfg_bytes_t applied_cfg;
  led_port_pkg::chan_bytes_t man_cur, man_duty, auto_cur;
  logic [3:0][7:0] q;
  logic [9:0] cmd_adr [8] = '{10'h010, 10'h011, 10'h013, 10'h011,
    10'h013, 10'h014, 10'h012, 10'h022};
  logic [7:0] cmd_bit [8] = '{8'h40, 8'h20, 8'h08, 8'h20, 8'h08, 8'h04,
    8'h10, 8'h02};
  logic [1:0] cmd_st [8] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h0, 2'h0};
  int err_count = 0;
  int tests_run = 0;
  always #2 sys_clk = ~sys_clk;
  // Pull-up wins whenever nobody pulls the data line low
  assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
  // Command outputs are one-cycle pulses, so keep the latest one
  always @(posedge sys_clk) begin
    if (!arst_n) last_cmd <= 8'h00;
    else if ((|cmd) === 1'b1) last_cmd <= cmd;
  end
  led_serial_port dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .status_in(status_in),
    .pat_rd_addr(pat_rd_addr), .pat_rd_data(pat_rd_data), .cmd(cmd),
    .drv_state(drv_state), .applied_cfg(applied_cfg),
    .chip_enable(chip_enable), .chan_enable(chan_enable),
    .manual_current_setting(man_cur), .manual_duty_setting(man_duty),
    .autonomous_current_setting(auto_cur));
  i2c_ctrl_model ctl_u (.sys_clk(sys_clk), .sda(sda), .scl(scl),
    .sda_pull(sda_pull));
  task automatic chk(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] hdr(input logic bc, input logic [9:0] a,
    input logic rd);
    return {bc ? 5'h1b : 5'h14, a[9:8], rd};
  endfunction
  // Fresh address bytes open every access
  task automatic addr(input logic bc, input logic [9:0] a);
    ctl_u.start();
    ctl_u.wr_byte(hdr(bc, a, 1'b0), ack);
    chk("ack chip", ack, 32'h1);
    ctl_u.wr_byte(a[7:0], ack);
    chk("ack addr", ack, 32'h1);
  endtask
  task automatic wbyte(input logic [7:0] d);
    ctl_u.wr_byte(d, ack);
    chk("ack data", ack, 32'h1);
  endtask
  task automatic wr1(input logic bc, input logic [9:0] a, input logic [7:0] d);
    addr(bc, a);
    wbyte(d);
    ctl_u.stop();
  endtask
  task automatic wr4(input logic bc, input logic [9:0] a,
    input logic [3:0][7:0] d);
    addr(bc, a);
    for (int k = 0; k < 4; k++) wbyte(d[k]);
    ctl_u.stop();
  endtask
  task automatic rdchk(input string what, input logic bc, input logic [9:0] a,
    input logic [31:0] exp);
    addr(bc, a);
    ctl_u.start();
    ctl_u.wr_byte(hdr(bc, a, 1'b1), ack);
    chk("ack read", ack, 32'h1);
    for (int k = 0; k < 4; k++) ctl_u.rd_byte(k == 3, q[k]);
    ctl_u.stop();
    chk(what, q, exp);
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    finish_test();
  end
  initial begin
    status_in = '0;
    status_in.thermal_cfg = 8'h81;
    for (int i = 0; i < 2; i++) status_in.open_led[i] = 8'h90 + 8'(i);
    for (int i = 0; i < 2; i++) status_in.short_led[i] = 8'ha0 + 8'(i);
    for (int i = 0; i < 16; i++) status_in.live_duty[i] = 8'hb0 + 8'(i);
    for (int i = 0; i < 8; i++) status_in.progress[i] = 8'hc0 + 8'(i);
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk("state at reset", drv_state, 32'h0);
    rdchk("reset regs", 1'b0, 10'h000, 32'h0);
    // Another variant's chip address must go unanswered
    ctl_u.start();
    ctl_u.wr_byte(8'hb0, ack);
    chk("ack other chip", ack, 32'h0);
    ctl_u.stop();
    wr1(1'b0, 10'h000, 8'h01);
    chk("enable pulse", last_cmd, 32'h80);
    chk("state enabled", drv_state, 32'h1);
    chk("chip enable", chip_enable, 32'h01);
    wr1(1'b0, 10'h020, 8'h0f);
    chk("channel enable", chan_enable, 32'h0f);
    for (int g = 0; g < 3; g++) begin
      wr4(g == 2, 10'h030 + 10'(g * 16), 32'h44332211 + 32'h10101010 * g);
      rdchk("group", g == 1, 10'h030 + 10'(g * 16),
        32'h44332211 + 32'h10101010 * g);
    end
    chk("manual current", man_cur, 32'h44332211);
    chk("manual duty", man_duty, 32'h54433221);
    chk("auto current", auto_cur, 32'h64534231);
    for (int ch = 0; ch < 4; ch++) begin
      wr1(1'b0, 10'h080 + 10'(ch * 26), 8'he0 + 8'(ch));
      pat_rd_addr = 7'(ch * 26);
      repeat (3) @(negedge sys_clk);
      chk("pattern block", pat_rd_data, 32'he0 + ch);
    end
    wr1(1'b0, 10'h001, 8'ha5);
    wr1(1'b0, 10'h00d, 8'h3c);
    chk("cfg held", {applied_cfg[12], applied_cfg[0]}, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr1(1'b0, cmd_adr[c], 8'h55);
      chk("cmd pulse", last_cmd, cmd_bit[c]);
      chk("cmd state", drv_state, cmd_st[c]);
    end
    chk("cfg applied", {applied_cfg[12], applied_cfg[0]}, 32'h3ca5);
    // Read-only place keeps the core's value after a write
    wr1(1'b0, 10'h300, 8'hff);
    rdchk("status", 1'b0, 10'h300, 32'ha0919081);
    rdchk("live duty", 1'b0, 10'h313, 32'hc1c0bfbe);
    rdchk("progress end", 1'b0, 10'h31c, 32'h000000c7);
    wr1(1'b0, 10'h023, 8'h5a);
    chk("soft reset cur", man_cur, 32'h0);
    chk("soft reset enable", chip_enable, 32'h0);
    chk("soft reset cfg", applied_cfg[0], 32'h0);
    rdchk("soft reset regs", 1'b0, 10'h020, 32'h0);
    finish_test();
  end
endmodule
`default_nettype wire
